// ### hdl/mtc_pkg.sv
// Function
// [R1] crc appended to each frame when crc-inhibit bit is 0, omitted when 1
// [R2] crc-inhibit stays effective in every loopback mode
// [R3] loop select field: 0 normal, 1 controller, 2 line codec, 3 external
// [R4] codec_loop_out high only for loop mode 2
// [R5] software clears loop_enable_n and programs loop field before loopback
// [R6] loop select bits are zero after reset
// [R7] remote disable on: multicast hash 62 stops, hash 63 restarts transmitter
// [R8] clearing remote_tx_disable re-enables a remotely stopped transmitter
// [R9] low priority backoff: range 2^min(3+n,10) slots for first three collisions
// [R10] transmit status cleared when the host starts the next transmission
// [R11] each status bit set only by its own event in the current transmission
// [R12] software reads status after each frame; undefined before the first
// [R13] tx ok flag only when no excess-retry abort and no underrun
// [R14] collided flag on any collision; collisions counted in collision_count
// [R15] abort and flag when attempts including the first reach 16
// [R16] carrier loss sets its flag and transmission continues
// [R17] fifo underrun sets its flag and aborts the frame
// [R18] heartbeat fail when no collision heartbeat within 6.4 us of gap
// [R19] collision after 51.2 us slot sets late flag, retried as normal
// [R20] loop_enable_n 0 means loopback enabled, 1 normal operation; codec_loop_out still follows loop mode 2 while it is 1
// [R21] writes to the three reserved config bits are ignored
// [R22] collision_count cleared at frame start, plus one per collision
package mtc_pkg;
  localparam int CLK_PERIOD_NS = 25;
  localparam int SLOT_TIME_NS = 51200;
  localparam int HB_WINDOW_NS = 6400;
  // slot is a least time, heartbeat window a longest time
  localparam int SLOT_CYCLES =
    (SLOT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HB_CYCLES = HB_WINDOW_NS / CLK_PERIOD_NS;
  localparam int MAX_ATTEMPTS = 16;
  localparam int BACKOFF_LIMIT = 10;
  localparam int OFFSET_COLLS = 3;
  localparam logic [5:0] HASH_TX_OFF = 6'h3e;
  localparam logic [5:0] HASH_TX_ON = 6'h3f;
  // register word indices; byte address is four times the index
  localparam logic [7:0] IDX_TX_CMD = 8'h00;
  localparam logic [7:0] IDX_TX_STATUS = 8'h04;
  localparam logic [7:0] IDX_COLL_COUNT = 8'h05;
  localparam logic [7:0] IDX_TX_CONFIG = 8'h0d;
  localparam logic [7:0] IDX_DATA_CONFIG = 8'h0e;
  // transmit_config fields
  localparam int CFG_CRC_INH = 0;
  localparam int CFG_LOOP_LO = 1;
  localparam int CFG_LOOP_HI = 2;
  localparam int CFG_REMOTE_DIS = 3;
  localparam int CFG_LOW_PRI = 4;
  localparam int CFG_WIDTH = 5;
  localparam logic [4:0] CFG_RESET = 5'h00;
  // transmit_status fields
  localparam int TS_TX_OK = 0;
  localparam int TS_COLLIDED = 2;
  localparam int TS_EXCESS = 3;
  localparam int TS_CARRIER = 4;
  localparam int TS_UNDERRUN = 5;
  localparam int TS_HEARTBEAT = 6;
  localparam int TS_LATE = 7;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  // data_config and command fields
  localparam int DCFG_LOOP_EN_N = 3;
  localparam logic LOOP_EN_N_RESET = 1'b1;
  localparam int CMD_START = 0;
  localparam int CMD_BUSY = 0;
  localparam int CMD_TX_EN = 1;
  localparam logic [15:0] LFSR_SEED = 16'hace1;

  typedef enum logic [1:0] {
    LOOP_NORMAL = 2'h0,
    LOOP_CONTROLLER = 2'h1,
    LOOP_CODEC = 2'h2,
    LOOP_EXTERNAL = 2'h3
  } mtc_loop_t;

  typedef enum logic [3:0] {
    S_IDLE = 4'h1,
    S_SEND = 4'h2,
    S_BACKOFF = 4'h4,
    S_GAP = 4'h8
  } mtc_state_t;
endpackage

// ### hdl/mtc_backoff.sv
`timescale 1ns/100ps
module mtc_backoff #(
  parameter int SLOT_CYC = mtc_pkg::SLOT_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic start,
  input wire logic [4:0] attempt,
  input wire logic low_pri,
  output logic done
);
  import mtc_pkg::*;

  localparam int TW = $clog2(SLOT_CYC + 1);

  if (SLOT_CYC < 2) begin : g_bad_slot
    $error("mtc_backoff: SLOT_CYC too small");
  end

  typedef struct packed {
    logic [15:0] lfsr;
    logic busy;
    logic [9:0] slots;
    logic [TW-1:0] tick;
    logic done;
  } mtc_bo_t;

  mtc_bo_t r;
  mtc_bo_t next_r;
  logic [3:0] expo;
  logic [9:0] mask;

  always_comb begin
    next_r = r;
    next_r.done = 1'b0;
    next_r.lfsr = {r.lfsr[14:0],
                   r.lfsr[15] ^ r.lfsr[13] ^ r.lfsr[12] ^ r.lfsr[10]};
    // [R9] exponent of range
    if (low_pri && attempt <= 5'(OFFSET_COLLS)) begin
      expo = (attempt + 5'd3 > 5'(BACKOFF_LIMIT)) ? 4'(BACKOFF_LIMIT)
                                                   : 4'(attempt + 5'd3);
    end else begin
      expo = (attempt > 5'(BACKOFF_LIMIT)) ? 4'(BACKOFF_LIMIT)
                                            : attempt[3:0];
    end
    mask = 10'(~(11'h7ff << expo));
    if (start) begin
      next_r.busy = 1'b1;
      next_r.slots = r.lfsr[9:0] & mask;
      next_r.tick = '0;
    end else if (r.busy) begin
      if (r.slots == 10'h000) begin
        next_r.busy = 1'b0;
        next_r.done = 1'b1;
      end else if (r.tick == TW'(SLOT_CYC - 1)) begin
        next_r.tick = '0;
        next_r.slots = r.slots - 10'h001;
      end else begin
        next_r.tick = r.tick + 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '{lfsr: LFSR_SEED, busy: 1'b0, slots: 10'h000,
             tick: '0, done: 1'b0};
    end else begin
      r <= next_r;
    end
  end

  assign done = r.done;

  chk_backoff_low_pri: assert property ( // [R9]
    @(posedge pclk) disable iff (!presetn)
    start && low_pri && attempt == 5'd1 |=> r.slots <= 10'h00f)
    else $error("low priority backoff range wrong");

  chk_backoff_std: assert property ( // [R9]
    @(posedge pclk) disable iff (!presetn)
    start && !low_pri && attempt == 5'd1 |=> r.slots <= 10'h001)
    else $error("standard backoff range wrong");
endmodule // mtc_backoff

// ### hdl/mtc_tx_ctrl.sv
// The APB interface to the registers was decided locally.
`timescale 1ns/100ps
module mtc_tx_ctrl #(
  parameter int ADDR_W = 12,
  parameter int SLOT_CYC = mtc_pkg::SLOT_CYCLES,
  parameter int HB_CYC = mtc_pkg::HB_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic tx_go,
  output logic tx_abort,
  output logic crc_append,
  output logic [1:0] loop_mode,
  output logic loop_active,
  output logic codec_loop_out,
  output logic tx_enabled,
  input wire logic frame_end,
  input wire logic coll_in,
  input wire logic carrier_in,
  input wire logic fifo_empty,
  input wire logic mcast_hit,
  input wire logic [5:0] mcast_hash
);
  import mtc_pkg::*;

  localparam int AW = ADDR_W - 2;
  localparam int TW = $clog2(SLOT_CYC + 1);

  if (ADDR_W < 10 || ADDR_W > 32) begin : g_bad_addr
    $error("mtc_tx_ctrl: ADDR_W out of range");
  end
  if (HB_CYC < 1 || HB_CYC >= SLOT_CYC) begin : g_bad_time
    $error("mtc_tx_ctrl: HB_CYC must be below SLOT_CYC");
  end

  typedef struct packed {
    mtc_state_t state;
    logic [CFG_WIDTH-1:0] cfg;
    logic loop_en_n;
    logic codec_loop;
    logic tx_off;
    logic pend;
    logic [7:0] status;
    logic [4:0] colls;
    logic [TW-1:0] timer;
    logic coll_d;
    logic abort;
    logic [31:0] rdata;
  } mtc_ctrl_t;

  mtc_ctrl_t r;
  mtc_ctrl_t next_r;
  logic [AW-1:0] word;
  logic hit;
  logic wr;
  logic rd_setup;
  logic coll_ev;
  logic late;
  logic bo_start;
  logic bo_done;
  logic [4:0] colls_inc;

  assign word = paddr[ADDR_W-1:2];
  assign hit = word == AW'(IDX_TX_CMD) || word == AW'(IDX_TX_STATUS)
            || word == AW'(IDX_COLL_COUNT) || word == AW'(IDX_TX_CONFIG)
            || word == AW'(IDX_DATA_CONFIG);
  // zero wait state slave
  assign pready = 1'b1;
  assign pslverr = psel && penable && !hit;
  assign wr = psel && penable && pwrite && hit;
  assign rd_setup = psel && !penable && !pwrite;
  assign coll_ev = coll_in && !r.coll_d;
  assign late = r.timer >= TW'(SLOT_CYC);
  assign colls_inc = r.colls + 5'd1;

  mtc_backoff #(
    .SLOT_CYC(SLOT_CYC)
  ) u_backoff (
    .pclk(pclk),
    .presetn(presetn),
    .start(bo_start),
    .attempt(colls_inc),
    .low_pri(r.cfg[CFG_LOW_PRI]),
    .done(bo_done)
  );

  always_comb begin
    next_r = r;
    next_r.abort = 1'b0;
    next_r.coll_d = coll_in;
    bo_start = 1'b0;

    // [R21] only the five defined bits are stored
    if (wr && word == AW'(IDX_TX_CONFIG)) begin
      next_r.cfg = pwdata[CFG_WIDTH-1:0];
    end
    // [R20] loopback enable is active low
    if (wr && word == AW'(IDX_DATA_CONFIG)) begin
      next_r.loop_en_n = pwdata[DCFG_LOOP_EN_N];
    end

    // [R4] codec loop only in mode 2
    next_r.codec_loop =
      next_r.cfg[CFG_LOOP_HI:CFG_LOOP_LO] == LOOP_CODEC;

    // [R8] clearing remote disable restarts the transmitter
    if (!next_r.cfg[CFG_REMOTE_DIS]) begin
      next_r.tx_off = 1'b0;
    // [R7] multicast hash 62 stops, 63 restarts
    end else if (mcast_hit && mcast_hash == HASH_TX_OFF) begin
      next_r.tx_off = 1'b1;
    end else if (mcast_hit && mcast_hash == HASH_TX_ON) begin
      next_r.tx_off = 1'b0;
    end

    unique case (r.state)
      S_IDLE: begin
        // a start while remotely disabled waits for re-enable
        if (r.pend && !r.tx_off) begin
          next_r.pend = 1'b0;
          // [R10] status cleared at host start
          next_r.status = STATUS_RESET;
          // [R22] count restarts with the frame
          next_r.colls = 5'd0;
          next_r.timer = '0;
          next_r.state = S_SEND;
        end
      end
      S_SEND: begin
        // [R11] each flag only from its own event
        if (!late) begin
          next_r.timer = r.timer + 1'b1;
        end
        // [R16] carrier loss flagged, frame goes on
        if (!carrier_in) begin
          next_r.status[TS_CARRIER] = 1'b1;
        end
        if (fifo_empty) begin
          // [R17] underrun aborts the frame
          next_r.status[TS_UNDERRUN] = 1'b1;
          next_r.abort = 1'b1;
          next_r.timer = '0;
          next_r.state = S_GAP;
        end else if (coll_ev) begin
          // [R14] collided flag and count
          next_r.status[TS_COLLIDED] = 1'b1;
          next_r.colls = colls_inc;
          // [R19] late collision flagged, retried as usual
          if (late) begin
            next_r.status[TS_LATE] = 1'b1;
          end
          // [R15] sixteenth attempt collided
          if (colls_inc == 5'(MAX_ATTEMPTS)) begin
            next_r.status[TS_EXCESS] = 1'b1;
            next_r.abort = 1'b1;
            next_r.state = S_IDLE;
          end else begin
            bo_start = 1'b1;
            next_r.state = S_BACKOFF;
          end
        end else if (frame_end) begin
          // [R13] reached only without abort or underrun
          next_r.status[TS_TX_OK] = 1'b1;
          next_r.timer = '0;
          next_r.state = S_GAP;
        end
      end
      S_BACKOFF: begin
        if (bo_done) begin
          next_r.timer = '0;
          next_r.state = S_SEND;
        end
      end
      S_GAP: begin
        next_r.timer = r.timer + 1'b1;
        // [R18] heartbeat must start inside the window
        if (coll_in) begin
          next_r.state = S_IDLE;
        end else if (r.timer == TW'(HB_CYC - 1)) begin
          next_r.status[TS_HEARTBEAT] = 1'b1;
          next_r.state = S_IDLE;
        end
      end
    endcase

    // a start landing on the launch edge stays pending
    if (wr && word == AW'(IDX_TX_CMD) && pwdata[CMD_START]) begin
      next_r.pend = 1'b1;
    end

    if (rd_setup) begin
      next_r.rdata = 32'h0000_0000;
      if (word == AW'(IDX_TX_CMD)) begin
        next_r.rdata[CMD_BUSY] = r.state != S_IDLE || r.pend;
        next_r.rdata[CMD_TX_EN] = !r.tx_off;
      end else if (word == AW'(IDX_TX_STATUS)) begin
        next_r.rdata[7:0] = r.status;
      end else if (word == AW'(IDX_COLL_COUNT)) begin
        next_r.rdata[4:0] = r.colls;
      end else if (word == AW'(IDX_DATA_CONFIG)) begin
        next_r.rdata[DCFG_LOOP_EN_N] = r.loop_en_n;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      // [R6] loop select starts at normal operation
      r <= '{state: S_IDLE, cfg: CFG_RESET, loop_en_n: LOOP_EN_N_RESET,
             codec_loop: 1'b0, tx_off: 1'b0, pend: 1'b0,
             status: STATUS_RESET, colls: 5'd0, timer: '0,
             coll_d: 1'b0, abort: 1'b0, rdata: 32'h0000_0000};
    end else begin
      r <= next_r;
    end
  end

  assign prdata = r.rdata;
  assign tx_go = r.state == S_SEND;
  assign tx_abort = r.abort;
  // [R1] [R2] crc control independent of loop mode
  assign crc_append = !r.cfg[CFG_CRC_INH];
  // [R3] loop field passed to the datapath
  assign loop_mode = r.cfg[CFG_LOOP_HI:CFG_LOOP_LO];
  // [R20] loop_active needs both a nonzero loop field and loop_enable_n low
  assign loop_active = loop_mode != LOOP_NORMAL && !r.loop_en_n;
  assign codec_loop_out = r.codec_loop;
  assign tx_enabled = !r.tx_off;

  chk_crc_write: assert property ( // [R1]
    @(posedge pclk) disable iff (!presetn)
    wr && word == AW'(IDX_TX_CONFIG)
    |=> crc_append == !$past(pwdata[CFG_CRC_INH]))
    else $error("crc append does not follow config");

  chk_codec_loop: assert property ( // [R4]
    @(posedge pclk) disable iff (!presetn)
    codec_loop_out == (loop_mode == LOOP_CODEC))
    else $error("codec loop output wrong for mode");

  chk_loop_reserved: assert property ( // [R21]
    @(posedge pclk) disable iff (!presetn)
    wr && word == AW'(IDX_TX_CONFIG) && pwdata[7:5] != 3'h0
    |=> r.cfg == $past(pwdata[4:0]))
    else $error("reserved config bits had effect");

  chk_remote_off: assert property ( // [R7]
    @(posedge pclk) disable iff (!presetn)
    r.cfg[CFG_REMOTE_DIS] && mcast_hit && mcast_hash == HASH_TX_OFF
    && !(wr && word == AW'(IDX_TX_CONFIG)) |=> !tx_enabled)
    else $error("hash 62 did not disable transmitter");

  chk_remote_clear: assert property ( // [R8]
    @(posedge pclk) disable iff (!presetn)
    wr && word == AW'(IDX_TX_CONFIG) && !pwdata[CFG_REMOTE_DIS]
    |=> tx_enabled)
    else $error("clearing remote disable left tx off");

  chk_status_clear: assert property ( // [R10]
    @(posedge pclk) disable iff (!presetn)
    r.state == S_IDLE && r.pend && !r.tx_off
    |=> r.status == STATUS_RESET && r.colls == 5'd0 && tx_go)
    else $error("status not cleared at start");

  chk_tx_ok_clean: assert property ( // [R13]
    @(posedge pclk) disable iff (!presetn)
    $rose(r.status[TS_TX_OK])
    |-> !r.status[TS_EXCESS] && !r.status[TS_UNDERRUN])
    else $error("tx ok set with abort or underrun");

  chk_coll_count: assert property ( // [R22]
    @(posedge pclk) disable iff (!presetn)
    tx_go && coll_ev && !fifo_empty
    |=> r.colls == $past(r.colls) + 5'd1 && r.status[TS_COLLIDED])
    else $error("collision not counted");

  chk_excess_abort: assert property ( // [R15]
    @(posedge pclk) disable iff (!presetn)
    tx_go && coll_ev && !fifo_empty && r.colls == 5'd15
    |=> r.status[TS_EXCESS] && tx_abort && r.state == S_IDLE)
    else $error("no abort at sixteenth attempt");

  chk_carrier_lost: assert property ( // [R16]
    @(posedge pclk) disable iff (!presetn)
    tx_go && !carrier_in && !fifo_empty && !coll_ev && !frame_end
    |=> r.status[TS_CARRIER] && tx_go && !tx_abort)
    else $error("carrier loss mishandled");

  chk_underrun: assert property ( // [R17]
    @(posedge pclk) disable iff (!presetn)
    tx_go && fifo_empty
    |=> r.status[TS_UNDERRUN] && tx_abort && !tx_go)
    else $error("underrun did not abort");

  chk_heartbeat: assert property ( // [R18]
    @(posedge pclk) disable iff (!presetn)
    r.state == S_GAP && r.timer == TW'(HB_CYC - 1) && !coll_in
    |=> r.status[TS_HEARTBEAT] && r.state == S_IDLE)
    else $error("heartbeat failure not flagged");

  chk_late_coll: assert property ( // [R19]
    @(posedge pclk) disable iff (!presetn)
    tx_go && coll_ev && !fifo_empty && late && r.colls < 5'd15
    |=> r.status[TS_LATE] && r.state == S_BACKOFF)
    else $error("late collision mishandled");

  chk_status_hold: assert property ( // [R11]
    @(posedge pclk) disable iff (!presetn)
    r.state == S_IDLE && !(r.pend && !r.tx_off) |=> $stable(r.status))
    else $error("status changed outside a transmission");

  chk_tx_ok_frame: assert property ( // [R13]
    @(posedge pclk) disable iff (!presetn)
    tx_go && frame_end && !fifo_empty && !coll_ev
    |=> r.status[TS_TX_OK] && r.state == S_GAP)
    else $error("clean frame end not flagged");

  chk_abort_pulse: assert property ( // [R17]
    @(posedge pclk) disable iff (!presetn)
    tx_abort |=> !tx_abort)
    else $error("abort pulse longer than one cycle");

  chk_retry_resume: assert property ( // [R19]
    @(posedge pclk) disable iff (!presetn)
    r.state == S_BACKOFF && bo_done |=> tx_go && r.timer == '0)
    else $error("frame not resent after backoff");
endmodule // mtc_tx_ctrl

// ### dv/mtc_medium.sv
`timescale 1ns/100ps
module mtc_medium #(
  parameter int SLOT = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic tx_go,
  input wire logic [2:0] mode,
  output logic frame_end,
  output logic coll_in,
  output logic carrier_in,
  output logic fifo_empty
);
  int cyc;
  int ncol;
  int gap;
  logic hit;
  // mode 4 collides once early, 6 once past a slot, 5 on every attempt
  always_comb begin
    hit = tx_go && ((mode == 3'd5 && cyc == 3) ||
      (ncol == 0 && mode == 3'd4 && cyc == 3) ||
      (ncol == 0 && mode == 3'd6 && cyc == SLOT + 2));
  end
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cyc <= 0;
      ncol <= 0;
      gap <= 0;
      frame_end <= 1'b0;
      coll_in <= 1'b0;
      carrier_in <= 1'b1;
      fifo_empty <= 1'b0;
    end else begin
      cyc <= tx_go ? cyc + 1 : 0;
      fifo_empty <= tx_go && mode == 3'd3 && cyc == 3;
      frame_end <= tx_go && mode != 3'd3 && cyc == SLOT + 8;
      carrier_in <= !(tx_go && mode == 3'd2 && (cyc == 2 || cyc == 3));
      // heartbeat early in the gap, left out in mode 1
      coll_in <= hit || (gap == 2 && mode != 3'd1);
      if (hit)
        ncol <= ncol + 1;
      if (frame_end || fifo_empty) begin
        ncol <= 0;
        gap <= 1;
      end else if (gap != 0 && gap < 4)
        gap <= gap + 1;
      else
        gap <= 0;
    end
  end
endmodule // mtc_medium

// ### dv/testbench.sv
`timescale 1ns/100ps
module testbench;
  import mtc_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic mcast_hit = 1'b0;
  logic [5:0] mcast_hash = 6'h00;
  logic [2:0] med_mode = 3'd0;
  logic [31:0] prdata, rdv;
  logic pready, pslverr, errv, go_q;
  logic tx_go, tx_abort, crc_append, loop_active, codec_loop_out, tx_enabled;
  logic [1:0] loop_mode;
  logic frame_end, coll_in, carrier_in, fifo_empty;
  int err_total = 0;
  int total_checks = 0;
  int n_att = 0;
  int n_abort = 0;

  always #12.5 pclk = ~pclk;

  mtc_tx_ctrl #(.ADDR_W(12), .SLOT_CYC(8), .HB_CYC(6)) u_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .tx_go(tx_go),
    .tx_abort(tx_abort), .crc_append(crc_append), .loop_mode(loop_mode),
    .loop_active(loop_active), .codec_loop_out(codec_loop_out),
    .tx_enabled(tx_enabled), .frame_end(frame_end), .coll_in(coll_in),
    .carrier_in(carrier_in), .fifo_empty(fifo_empty),
    .mcast_hit(mcast_hit), .mcast_hash(mcast_hash));

  mtc_medium #(.SLOT(8)) u_medium (
    .pclk(pclk), .presetn(presetn), .tx_go(tx_go), .mode(med_mode),
    .frame_end(frame_end), .coll_in(coll_in), .carrier_in(carrier_in),
    .fifo_empty(fifo_empty));

  // attempts seen on the wire and abort pulses
  always @(posedge pclk) begin
    go_q <= tx_go;
    if (tx_go === 1'b1 && go_q === 1'b0)
      n_att <= n_att + 1;
    if (tx_abort === 1'b1)
      n_abort <= n_abort + 1;
  end

  task automatic end_of_test;
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic cmp32(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("Error t=%0t value %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cmp_pin(input logic [3:0] got, input logic [3:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("Error t=%0t pins %b expected %b", $time, got, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] idx,
      input logic [31:0] wd, output logic [31:0] rd, output logic err);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    apb(1'b1, idx, d, rdv, errv);
  endtask

  task automatic rd_chk(input logic [7:0] idx, input logic [31:0] exp);
    apb(1'b0, idx, 32'h0, rdv, errv);
    cmp32(rdv, exp);
    cmp_pin({3'b0, errv}, 4'h0);
  endtask

  task automatic send(input logic [2:0] m, input logic [7:0] st,
      input logic [7:0] nc, input int att);
    med_mode <= m;
    n_att = 0;
    wr(IDX_TX_CMD, 32'h1);
    // a hang is caught by the watchdog
    do
      apb(1'b0, IDX_TX_CMD, 32'h0, rdv, errv);
    while (rdv[CMD_BUSY] !== 1'b0);
    rd_chk(IDX_TX_STATUS, {24'h0, st});
    rd_chk(IDX_COLL_COUNT, {24'h0, nc});
    cmp32(n_att, att);
  endtask

  task automatic mc(input logic [5:0] h);
    mcast_hash <= h;
    mcast_hit <= 1'b1;
    @(posedge pclk);
    mcast_hit <= 1'b0;
    repeat (2) @(posedge pclk);
  endtask

  initial begin
    #2500000;
    err_total++;
    end_of_test();
  end

  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    cmp_pin({tx_go, crc_append, loop_mode}, 4'b0100);
    cmp_pin({codec_loop_out, loop_active, tx_enabled, tx_abort}, 4'b0010);
    rd_chk(IDX_DATA_CONFIG, 32'h8);
    apb(1'b0, 8'h3f, 32'h0, rdv, errv);
    cmp32(rdv, 32'h0);
    cmp_pin({3'b0, errv}, 4'h1);
    wr(IDX_DATA_CONFIG, 32'h0);
    for (int m = 0; m < 8; m++) begin
      wr(IDX_TX_CONFIG, {24'h0, 3'b111, 2'b00, m[1:0], m[2]});
      cmp_pin({2'b0, loop_mode}, {2'b0, m[1:0]});
      cmp_pin({3'b0, codec_loop_out}, {3'b0, m[1:0] == 2'd2});
      cmp_pin({3'b0, crc_append}, {3'b0, !m[2]});
      cmp_pin({3'b0, loop_active}, {3'b0, m[1:0] != 2'd0});
    end
    rd_chk(IDX_TX_CONFIG, 32'h0);
    wr(IDX_DATA_CONFIG, 32'h8);
    cmp_pin({3'b0, loop_active}, 4'h0);
    wr(IDX_TX_CONFIG, 32'h0);
    // status read after every frame
    send(3'd0, 8'h01, 8'h00, 1);
    wr(IDX_TX_STATUS, 32'hff);
    rd_chk(IDX_TX_STATUS, 32'h01);
    send(3'd1, 8'h41, 8'h00, 1);
    send(3'd2, 8'h11, 8'h00, 1);
    send(3'd3, 8'h20, 8'h00, 1);
    cmp32(n_abort, 1);
    wr(IDX_TX_CONFIG, 32'h10);
    send(3'd4, 8'h05, 8'h01, 2);
    wr(IDX_TX_CONFIG, 32'h0);
    send(3'd6, 8'h85, 8'h01, 2);
    send(3'd0, 8'h01, 8'h00, 1);
    wr(IDX_TX_CONFIG, 32'h8);
    mc(HASH_TX_OFF);
    cmp_pin({3'b0, tx_enabled}, 4'h0);
    rd_chk(IDX_TX_CMD, 32'h0);
    mc(6'h3d);
    cmp_pin({3'b0, tx_enabled}, 4'h0);
    mc(HASH_TX_ON);
    cmp_pin({3'b0, tx_enabled}, 4'h1);
    mc(HASH_TX_OFF);
    cmp_pin({3'b0, tx_enabled}, 4'h0);
    wr(IDX_TX_CONFIG, 32'h0);
    cmp_pin({3'b0, tx_enabled}, 4'h1);
    rd_chk(IDX_TX_CMD, 32'h2);
    send(3'd5, 8'h0c, 8'h10, 16);
    cmp32(n_abort, 2);
    end_of_test();
  end
endmodule // testbench
